// ==== hdl/csel_params.svh ====
// Offsets, field width, reset values and timing counts of the selector
`ifndef CSEL_PARAMS_SVH
`define CSEL_PARAMS_SVH
`define CSEL_OFS_TRIM       12'h000
`define CSEL_OFS_STATUS     12'h004
`define CSEL_OFS_CFG        12'h008
`define CSEL_TRIM_W         5
`define CSEL_TRIM_RST       5'h00
`define CSEL_XTAL_COUNT     1024
`define CSEL_RC_INSTR       2
`define CSEL_CLKS_PER_INSTR 4
`define CSEL_CLK_MHZ        50
`define CSEL_FAST_MHZ       8
`define CSEL_SLOW_MHZ       4
`endif

// ==== hdl/csel_pkg.sv ====
// Types shared by the clock source selector
package csel_pkg;
  typedef enum logic [2:0] {
    WATCH_CRYSTAL  = 3'h0,
    MEDIUM_CRYSTAL = 3'h1,
    HIGH_CRYSTAL   = 3'h2,
    EXT_CLOCK      = 3'h3,
    INT_CLK_ALL_IO = 3'h4,
    INT_CLK_OUT    = 3'h5,
    RC_ALL_IO      = 3'h6,
    RC_WITH_OUT    = 3'h7
  } csel_mode_t;
  typedef struct packed {
    logic in_is_gpio;
    logic out_is_gpio;
    logic out_is_div4;
    logic [1:0] gain;
  } csel_pins_t;
endpackage

// ==== hdl/csel_div4.sv ====
// Divide-by-4 clock output generator from a source edge enable
`timescale 1ns/1ps
module csel_div4 (
  input  wire logic clk,      // System clock
  input  wire logic nrst,     // Synchronous reset, low
  input  wire logic src_tick, // One pulse per source cycle
  input  wire logic run,      // Counting allowed
  output logic      div_out   // Source divided by four
);
  logic [1:0] cnt;
  logic [1:0] next_cnt;

  // Next count on each source tick
  always_comb begin
    next_cnt = cnt;
    if (run && src_tick) begin
      next_cnt = cnt + 2'h1;
    end
  end

  // Register the count
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt <= 2'h0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign div_out = cnt[1];
endmodule // csel_div4

// ==== hdl/csel_internal_clock_with_output_mode.sv ====
// Internal oscillator tick generator with trim and fast or slow rate
`timescale 1ns/1ps
`include "csel_params.svh"
module csel_internal_clock_with_output_mode #(
  parameter int CLK_MHZ = `CSEL_CLK_MHZ
) (
  input  wire logic       clk,       // System clock
  input  wire logic       nrst,      // Synchronous reset, low
  input  wire logic       fast,      // High selects faster rate
  input  wire logic [4:0] trim,      // Signed trim value
  output logic            tick       // One pulse per oscillator cycle
);
  // Phase accumulator, increment scaled by nominal rate and trim
  localparam logic [15:0] BASE_FAST = 16'((`CSEL_FAST_MHZ * 65536) / CLK_MHZ);
  localparam logic [15:0] BASE_SLOW = 16'((`CSEL_SLOW_MHZ * 65536) / CLK_MHZ);
  logic [15:0] acc;
  logic [16:0] next_sum;
  logic [15:0] step;

  // Trim shifts the step monotonically, zero keeps calibration
  always_comb begin
    step     = fast ? BASE_FAST : BASE_SLOW;
    step     = step + 16'(signed'({{11{trim[4]}}, trim}) * 16'sd8);
    next_sum = {1'b0, acc} + {1'b0, step};
  end

  // Register the phase
  always_ff @(posedge clk) begin
    if (!nrst) begin
      acc  <= 16'h0000;
      tick <= 1'b0;
    end else begin
      acc  <= next_sum[15:0];
      tick <= next_sum[16];
    end
  end
endmodule // csel_internal_clock_with_output_mode

// ==== hdl/csel_top.sv ====
// Clock source selector: mode decode, start-up hold, trim register
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "csel_params.svh"
module csel_top #(
  parameter int XTAL_COUNT = `CSEL_XTAL_COUNT,
  parameter int RC_INSTR   = `CSEL_RC_INSTR
) (
  input  wire logic        CLK_SYS,     // System clock 50 MHz
  input  wire logic        NRST,        // Synchronous reset, low
  input  wire logic        POR_N,       // Power-on or brown-out, low
  input  wire logic        WAKE,        // Wake-up from sleep pulse
  input  wire logic [2:0]  CFG_MODE,    // Clock mode select field
  input  wire logic        CFG_IFREQ,   // Internal frequency select
  input  wire logic        CLKIN_TICK,  // Edge seen on clock input pin
  input  wire logic        PSEL,        // APB select
  input  wire logic        PENABLE,     // APB enable
  input  wire logic        PWRITE,      // APB direction
  input  wire logic [11:0] PADDR,       // APB address
  input  wire logic [31:0] PWDATA,      // APB write data
  output logic [31:0]      PRDATA,      // APB read data
  output logic             PREADY,      // APB ready
  output logic             PSLVERR,     // APB error
  output logic             CPU_HOLD,    // Hold program counter
  output logic             CLKOUT,      // Clock output pin value
  output logic             CLKOUT_OE,   // Clock output pin driven
  output logic             CLKIN_GPIO,  // Clock input pin free
  output logic             CLKOUT_GPIO, // Clock output pin free
  output logic [1:0]       AMP_GAIN,    // Amplifier gain, 0 off
  output logic             INT_TICK,    // Internal oscillator tick
  output logic [4:0]       TRIM         // Trim to oscillator
);
  typedef enum logic [1:0] {S_IDLE, S_XTAL, S_RC, S_RUN} csel_st_t;

  ////////////////////////////////////////////////////////////////////
  // Mode decode function
  function automatic csel_pkg::csel_pins_t decode(csel_pkg::csel_mode_t m);
    csel_pkg::csel_pins_t p;
    p = '0;
    case (m)
      csel_pkg::WATCH_CRYSTAL:  p.gain = 2'h1;
      csel_pkg::MEDIUM_CRYSTAL: p.gain = 2'h2;
      csel_pkg::HIGH_CRYSTAL:   p.gain = 2'h3;
      csel_pkg::EXT_CLOCK:      p.out_is_gpio = 1'b1;
      csel_pkg::INT_CLK_ALL_IO: begin
        p.in_is_gpio  = 1'b1;
        p.out_is_gpio = 1'b1;
      end
      csel_pkg::INT_CLK_OUT: begin
        p.in_is_gpio  = 1'b1;
        p.out_is_div4 = 1'b1;
      end
      csel_pkg::RC_ALL_IO:      p.out_is_gpio = 1'b1;
      csel_pkg::RC_WITH_OUT:    p.out_is_div4 = 1'b1;
      default:                  p = '0;
    endcase
    return p;
  endfunction

  // Crystal modes need the start-up count
  function automatic logic is_xtal(csel_pkg::csel_mode_t m);
    return (m == csel_pkg::WATCH_CRYSTAL) || (m == csel_pkg::MEDIUM_CRYSTAL)
        || (m == csel_pkg::HIGH_CRYSTAL);
  endfunction

  // Internal modes need no input pin
  function automatic logic is_int(csel_pkg::csel_mode_t m);
    return (m == csel_pkg::INT_CLK_ALL_IO) || (m == csel_pkg::INT_CLK_OUT);
  endfunction

  // Status word: run, crystal wait, RC wait
  function automatic logic [2:0] status_bits(csel_st_t s);
    return {s == S_RUN, s == S_XTAL, s == S_RC};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // State
  // RC delay counted in source ticks, four per instruction
  localparam int RC_TICKS = RC_INSTR * `CSEL_CLKS_PER_INSTR;
  csel_pkg::csel_mode_t mode, next_mode;
  logic        ifreq, next_ifreq;
  logic        latched, next_latched;
  csel_st_t    state, next_state;
  logic [10:0] cnt, next_cnt;
  logic [4:0]  trim, next_trim;
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr;
  logic        int_tick;
  logic        div_out;
  logic        src_tick;
  logic        running;
  csel_pkg::csel_pins_t pins;
  // Next values of the registered pins
  logic        next_cpu_hold;
  logic        next_clkout;
  logic        next_clkout_oe;
  logic        next_clkin_gpio;
  logic        next_clkout_gpio;
  logic [1:0]  next_amp_gain;
  logic        next_int_tick;
  logic [4:0]  next_trim_out;

  assign pins     = decode(mode);
  assign running  = (state == S_RUN);
  // Source edges: internal ticks or pin edges; none means frozen
  assign src_tick = is_int(mode) ? int_tick : CLKIN_TICK;

  // Configuration capture after reset
  always_comb begin
    next_mode    = mode;
    next_ifreq   = ifreq;
    next_latched = 1'b1;
    if (!latched) begin
      next_mode  = csel_pkg::csel_mode_t'(CFG_MODE);
      next_ifreq = CFG_IFREQ;
    end
  end

  // Register configuration; later field changes are ignored
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      mode    <= csel_pkg::EXT_CLOCK;
      ifreq   <= 1'b0;
      latched <= 1'b0;
    end else begin
      mode    <= next_mode;
      ifreq   <= next_ifreq;
      latched <= next_latched;
    end
  end

  // Start-up sequencer; a stopped source freezes the count
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      S_IDLE: begin
        if (latched) begin
          next_cnt = 11'h000;
          if (is_xtal(mode)) next_state = S_XTAL;
          else if (!is_int(mode) && mode != csel_pkg::EXT_CLOCK)
            next_state = S_RC;
          else next_state = S_RUN;
        end
      end
      S_XTAL: begin
        if (CLKIN_TICK) next_cnt = cnt + 11'h001;
        if (CLKIN_TICK && cnt == 11'(XTAL_COUNT - 1)) next_state = S_RUN;
      end
      S_RC: begin
        if (CLKIN_TICK) next_cnt = cnt + 11'h001;
        if (CLKIN_TICK && cnt == 11'(RC_TICKS - 1)) next_state = S_RUN;
      end
      S_RUN: begin
        if (WAKE) next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end

  // Register sequencer state
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      state <= S_IDLE;
      cnt   <= 11'h000;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // APB slave, one wait-free access cycle
  always_comb begin
    next_trim    = trim;
    next_prdata  = 32'h0000_0000;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    if (PSEL && !PENABLE) begin
      next_pready = 1'b1;
      case (PADDR)
        `CSEL_OFS_TRIM:   next_prdata = {27'h0, trim};
        `CSEL_OFS_STATUS: next_prdata = {29'h0, status_bits(state)};
        `CSEL_OFS_CFG:    next_prdata = {28'h0, ifreq, 3'(mode)};
        default:          next_pslverr = 1'b1;
      endcase
      // write applies at once, no flag
      if (PWRITE && PADDR == `CSEL_OFS_TRIM) begin
        next_trim = PWDATA[4:0];
      end
      // Writes return zero data
      if (PWRITE) next_prdata = 32'h0000_0000;
    end
  end

  // Trim register; other resets leave it alone
  always_ff @(posedge CLK_SYS) begin
    if (!POR_N) begin
      trim <= `CSEL_TRIM_RST;
    end else begin
      trim <= next_trim;
    end
  end

  // Register bus outputs
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PRDATA  <= next_prdata;
      PREADY  <= next_pready;
      PSLVERR <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // internal rate, signed trim
  csel_internal_clock_with_output_mode u_internal_clock_with_output_mode (
    .clk  (CLK_SYS),
    .nrst (NRST),
    .fast (ifreq),
    .trim (trim),
    .tick (int_tick)
  );

  csel_div4 u_div4 (
    .clk      (CLK_SYS),
    .nrst     (NRST),
    .src_tick (src_tick),
    .run      (running),
    .div_out  (div_out)
  );

  // Pin and control next values
  always_comb begin
    next_cpu_hold    = !running;
    next_clkout      = pins.out_is_div4 & div_out;
    next_clkout_oe   = pins.out_is_div4;
    next_clkin_gpio  = pins.in_is_gpio;
    next_clkout_gpio = pins.out_is_gpio;
    next_amp_gain    = pins.gain;
    // Internal ticks shown only in internal modes
    next_int_tick    = int_tick & is_int(mode);
    // Copy of trim for the oscillator
    next_trim_out    = trim;
  end

  // Registered pin and control outputs
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      CPU_HOLD    <= 1'b1;
      CLKOUT      <= 1'b0;
      CLKOUT_OE   <= 1'b0;
      CLKIN_GPIO  <= 1'b0;
      CLKOUT_GPIO <= 1'b0;
      AMP_GAIN    <= 2'h0;
      INT_TICK    <= 1'b0;
      TRIM        <= 5'h00;
    end else begin
      CPU_HOLD    <= next_cpu_hold;
      CLKOUT      <= next_clkout;
      CLKOUT_OE   <= next_clkout_oe;
      CLKIN_GPIO  <= next_clkin_gpio;
      CLKOUT_GPIO <= next_clkout_gpio;
      AMP_GAIN    <= next_amp_gain;
      INT_TICK    <= next_int_tick;
      TRIM        <= next_trim_out;
    end
  end
endmodule // csel_top

// ==== tb/csel_src.sv ====
// Model of the outside clock source on the input pin
`timescale 1ns/1ps
module csel_src #(
  parameter int DIV = 3
) (
  input  wire logic clk,  // Bench clock
  input  wire logic en,   // Source running
  output logic      tick  // Edge seen on input pin
);
  int cnt = 0;
  always @(posedge clk) begin
    cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
    tick <= en && cnt == 0;
  end
endmodule // csel_src

// ==== tb/csel_asserts.sv ====
// Port checker of the clock source selector
`timescale 1ns/1ps
module csel_asserts #(
  parameter int XTAL_COUNT = 1024,
  parameter int RC_INSTR   = 2
) (
  input wire logic        CLK_SYS,     // System clock
  input wire logic        NRST,        // Reset, low
  input wire logic        POR_N,       // Power-on reset, low
  input wire logic        WAKE,        // Wake pulse
  input wire logic [2:0]  CFG_MODE,    // Mode field
  input wire logic        CLKIN_TICK,  // Input pin edge
  input wire logic        PSEL,        // APB select
  input wire logic        PENABLE,     // APB enable
  input wire logic        PWRITE,      // APB direction
  input wire logic [11:0] PADDR,       // APB address
  input wire logic [31:0] PWDATA,      // APB write data
  input wire logic [31:0] PRDATA,      // APB read data
  input wire logic        PREADY,      // APB ready
  input wire logic        PSLVERR,     // APB error
  input wire logic        CPU_HOLD,    // Program counter hold
  input wire logic        CLKOUT,      // Output pin value
  input wire logic        CLKIN_GPIO,  // Input pin free
  input wire logic        CLKOUT_GPIO, // Output pin free
  input wire logic [1:0]  AMP_GAIN,    // Amplifier gain
  input wire logic [4:0]  TRIM         // Trim value
);
  int nt;
  int lim;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  ////////////////////////////////////////////////////////////////////////
  // Source edges seen while held
  always_ff @(posedge CLK_SYS) begin
    if (!NRST || WAKE) nt <= 0;
    else if (CLKIN_TICK && CPU_HOLD) nt <= nt + 1;
  end
  // Start-up length of the mode
  always_comb lim = (CFG_MODE < 3'h3) ? XTAL_COUNT
                  : (CFG_MODE > 3'h5) ? RC_INSTR * 4 : 0;
  ////////////////////////////////////////////////////////////////////////
  chk_apb_ready: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("ready missing after setup");
  chk_bad_addr: assert property (PSEL && !PENABLE && !(PADDR inside
    {12'h000, 12'h004, 12'h008}) |=> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access not refused");
  chk_trim_write: assert property (PSEL && !PENABLE && PWRITE && POR_N &&
    PADDR == 12'h000 |-> ##2 TRIM == $past(PWDATA[4:0], 2))
    else $error("trim write lost");
  chk_trim_upper: assert property (PREADY && !PWRITE &&
    PADDR == 12'h000 |-> PRDATA[31:5] == 27'h0)
    else $error("trim upper bits set");
  chk_pin_use: assert property (!CPU_HOLD |->
    CLKIN_GPIO == (CFG_MODE inside {3'h4, 3'h5}) &&
    CLKOUT_GPIO == (CFG_MODE inside {3'h3, 3'h4, 3'h6}))
    else $error("pin use wrong for mode");
  chk_gain_set: assert property (!CPU_HOLD |-> AMP_GAIN ==
    ((CFG_MODE < 3'h3) ? CFG_MODE[1:0] + 2'h1 : 2'h0))
    else $error("gain wrong for mode");
  chk_fast_start: assert property ($rose(NRST) &&
    CFG_MODE inside {3'h3, 3'h4, 3'h5} |-> ##[1:6] !CPU_HOLD)
    else $error("start-up too slow");
  chk_hold_len: assert property ($fell(CPU_HOLD) |->
    nt >= lim && nt <= lim + 3)
    else $error("start-up count wrong");
  chk_clkout_off: assert property (!(CFG_MODE inside {3'h5, 3'h7})
    |-> !CLKOUT)
    else $error("clock output active in wrong mode");
endmodule // csel_asserts

bind csel_top csel_asserts #(.XTAL_COUNT(XTAL_COUNT), .RC_INSTR(RC_INSTR))
  u_chk (.CLK_SYS(CLK_SYS), .NRST(NRST), .POR_N(POR_N), .WAKE(WAKE),
  .CFG_MODE(CFG_MODE), .CLKIN_TICK(CLKIN_TICK), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .CPU_HOLD(CPU_HOLD), .CLKOUT(CLKOUT), .CLKIN_GPIO(CLKIN_GPIO),
  .CLKOUT_GPIO(CLKOUT_GPIO), .AMP_GAIN(AMP_GAIN), .TRIM(TRIM));

// ==== tb/clock_source_selector_tb_top.sv ====
// Testbench of the clock source selector
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value at %0t: got %0h want %0h", $time, a, b); end end
module clock_source_selector_tb_top;
  logic clk = 0, nrst = 0, por_n = 0, wake = 0, ifreq = 0, en = 1;
  logic psel = 0, penable = 0, pwrite = 0, err, tick, hold, clkout;
  logic pready, pslverr, in_gpio, out_gpio, int_tick, oe;
  logic [2:0]  mode = 3'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0]  gain;
  logic [4:0]  trim, v;
  int n_fail = 0, n_compared = 0, cyc = 0, nc, ni, hi, lo, mid, ex;
  int trim_q[$];
  csel_src u_src (.clk(clk), .en(en), .tick(tick));
  csel_top dut (.CLK_SYS(clk), .NRST(nrst), .POR_N(por_n), .WAKE(wake),
    .CFG_MODE(mode), .CFG_IFREQ(ifreq), .CLKIN_TICK(tick), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CPU_HOLD(hold),
    .CLKOUT(clkout), .CLKOUT_OE(oe), .CLKIN_GPIO(in_gpio),
    .CLKOUT_GPIO(out_gpio), .AMP_GAIN(gain), .INT_TICK(int_tick),
    .TRIM(trim));
  ////////////////////////////////////////////////////////////////////////
  // Clock and hang limit
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One APB transfer, result in rd and err
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Reset with a mode, optionally power-on
  task automatic rst(input logic [2:0] md, input logic por);
    @(posedge clk);
    nrst <= 0;
    por_n <= !por;
    mode <= md;
    repeat (20) @(posedge clk);
    nrst <= 1;
    por_n <= 1;
  endtask
  // Wait for the end of start-up
  task automatic wait_run();
    int n;
    n = 0;
    while (hold !== 1'b0 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    `CHK(hold, 1'b0)
  endtask
  // Count output rises and oscillator ticks
  task automatic count(input int c);
    logic p;
    p = 0;
    nc = 0;
    ni = 0;
    repeat (c) begin
      @(negedge clk);
      if (int_tick === 1'b1) ni++;
      if (clkout === 1'b1 && !p) nc++;
      p = clkout === 1'b1;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'h9f80));
    for (int m = 0; m < 8; m++) begin
      ifreq <= 1'($urandom);
      rst(3'(m), m == 0);
      if (m == 0) begin
        en <= 0;
        repeat (100) @(posedge clk);
        `CHK(hold, 1'b1)
        en <= 1;
      end
      wait_run();
      `CHK(in_gpio, 1'(m == 4 || m == 5))
      `CHK(out_gpio, 1'(m == 3 || m == 4 || m == 6))
      `CHK(gain, 2'(m < 3 ? m + 1 : 0))
      `CHK(oe, 1'(m == 5 || m == 7))
      count(400);
      ex = m == 7 ? 33 : m == 5 ? (ifreq ? 16 : 8) : 0;
      `CHK(ex == 0 ? nc == 0 : nc >= ex - 2 && nc <= ex + 2, 1'b1)
      ex = (m == 4 || m == 5) ? (ifreq ? 64 : 32) : 0;
      `CHK(ex == 0 ? ni == 0 : ni >= ex - 2 && ni <= ex + 2, 1'b1)
    end
    ifreq <= 1;
    rst(3'h4, 0);
    wait_run();
    v = 5'($urandom);
    trim_q.push_back(v);
    apb(1, 12'h000, {27'($urandom), v});
    @(negedge clk);
    `CHK(trim, v)
    apb(0, 12'h000, 32'h0);
    `CHK(rd, 32'(trim_q[$]))
    apb(1, 12'h000, 32'hffffffff);
    apb(0, 12'h000, 32'h0);
    `CHK(rd, 32'h1f)
    apb(1, 12'h000, 32'h0f);
    count(2000);
    hi = ni;
    apb(1, 12'h000, 32'h10);
    count(2000);
    lo = ni;
    apb(1, 12'h000, 32'h00);
    count(2000);
    mid = ni;
    `CHK(hi > mid && mid > lo, 1'b1)
    apb(0, 12'h010, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
    apb(1, 12'h000, 32'h0b);
    rst(3'h4, 0);
    wait_run();
    apb(0, 12'h000, 32'h0);
    `CHK(rd, 32'h0b)
    rst(3'h4, 1);
    wait_run();
    apb(0, 12'h000, 32'h0);
    `CHK(rd, 32'h0)
    rst(3'h1, 0);
    wait_run();
    wake <= 1;
    @(posedge clk);
    wake <= 0;
    repeat (3) @(posedge clk);
    `CHK(hold, 1'b1)
    wait_run();
    end_sim();
  end
endmodule // clock_source_selector_tb_top
